// ==== verilog/flash_sr_pkg.sv ====
package flash_sr_pkg;

  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_RESUME = 8'hD0;
  localparam logic [7:0] PROT_BYTE1 = 8'h3D;
  localparam logic [7:0] PROT_BYTE2 = 8'h2A;
  localparam logic [7:0] PROT_BYTE3 = 8'h7F;
  localparam logic [7:0] PROT_EN_BYTE4 = 8'hA9;
  localparam logic [7:0] PROT_DIS_BYTE4 = 8'h9A;

  // Sector protection register byte values
  localparam logic [7:0] SECT_PROT_ON = 8'hFF;
  localparam logic [1:0] SUB_PROT_ON = 2'h3;
  localparam int SUB0A_LSB = 6;
  localparam int SUB0B_LSB = 4;
  localparam int SECTORS = 8;

  localparam int CMD_BYTES = 4;
  localparam int CLK_PERIOD_NS = 40;
  // Resume latency figure is not fixed here; plain default
  localparam int RESUME_LATENCY_NS = 20000;
  localparam int RESUME_CYCLES_DEF =
    (RESUME_LATENCY_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (RESUME_LATENCY_NS / CLK_PERIOD_NS);

  // Classes handed over by the main opcode decoder at frame end
  typedef enum logic [4:0] {
    K_NONE, K_READ_ARRAY, K_READ_BUF, K_BUF1_WRITE, K_BUF2_WRITE,
    K_PROG_ERASE, K_PROG_NOERASE, K_PAGE_BLOCK_ERASE, K_SECTOR_ERASE,
    K_CHIP_ERASE, K_PROT_REG_ERASE, K_PROT_REG_PROG, K_LOCKDOWN,
    K_LOCK_FREEZE, K_SEC_PROG, K_READ_PROT, K_READ_LOCK, K_READ_SEC,
    K_XFER_BUF1, K_XFER_BUF2, K_CMP_BUF1, K_CMP_BUF2, K_DPD_ENTER,
    K_DPD_EXIT, K_UDPD_ENTER, K_READ_CFG, K_READ_STATUS, K_READ_ID,
    K_SOFT_RESET, K_PROT_ENABLE, K_PROT_DISABLE
  } cmd_kind_t;

  typedef enum {ST_IDLE, ST_RESTART} resume_state_t;

endpackage : flash_sr_pkg

// ==== verilog/frame_collect.sv ====
`timescale 1ns/1ps
module frame_collect
  import flash_sr_pkg::*;
(
  input wire logic ref_clk, // 25 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire logic cs_active, // Chip select asserted (level)
  input wire logic byte_valid, // One received byte (pulse)
  input wire logic [7:0] byte_data, // Received byte
  output logic frame_end, // Chip select just released (pulse)
  output logic [7:0] byte1_q, // First byte of frame
  output logic prefix_q, // Bytes 2 and 3 match protect prefix
  output logic [7:0] byte4_q, // Fourth byte of frame
  output logic [2:0] nbytes_q // Bytes seen, saturating
);

  logic cs_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cs_q <= 1'b0;
    end else begin
      cs_q <= cs_active;
    end
  end

  assign frame_end = cs_q & ~cs_active;

  // Bytes past the fourth are dropped, so trailing data never matters
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      nbytes_q <= 3'h0;
      byte1_q <= 8'h00;
      byte4_q <= 8'h00;
      prefix_q <= 1'b0;
    end else if (cs_active && !cs_q) begin
      nbytes_q <= byte_valid ? 3'h1 : 3'h0;
      byte1_q <= byte_valid ? byte_data : 8'h00;
      byte4_q <= 8'h00;
      prefix_q <= 1'b1;
    end else if (cs_active && byte_valid && nbytes_q < 3'(CMD_BYTES)) begin
      nbytes_q <= nbytes_q + 3'h1;
      case (nbytes_q)
        3'h0: byte1_q <= byte_data;
        3'h1: prefix_q <= prefix_q & (byte_data == PROT_BYTE2);
        3'h2: prefix_q <= prefix_q & (byte_data == PROT_BYTE3);
        3'h3: byte4_q <= byte_data;
        default: byte4_q <= byte4_q;
      endcase
    end
  end

endmodule : frame_collect

// ==== verilog/flash_suspend_resume_protect.sv ====
// What this block does
// - During any suspend, refuse erase, protection, lockdown and security programming.
// - During any suspend, accept protection, lockdown and security register reads.
// - Buffer transfer refused only when that same buffer is program suspended.
// - Buffer compares accepted in every suspend state.
// - During any suspend, refuse deep and ultra-deep power-down and power-up.
// - During any suspend, accept config, status, id reads and reset.
// - Resume is opcode D0h alone; further bytes are ignored.
// - After chip select release, restart suspended work within resume latency.
// - On resume clear the matching suspend flag and report busy.
// - With program and erase both suspended, resume program first.
// - Suspend commands are ignored while a resume is restarting.
// - Status shows protection enabled by software or by the protect pin.
// - Undriven write-protect input is taken as deasserted.
// - Software protection is volatile and off after power-up.
// - 3Dh 2Ah 7Fh A9h then chip select release enables protection.
// - 3Dh 2Ah 7Fh 9Ah then chip select release disables protection, unless the protect pin is asserted.
// - With protection on, block program and erase only in marked sectors.
// - Opcode B0h on release sets the matching suspend flag, reports ready.
// - Sectors 1 to 7 protected by FFh, unprotected by 00h.
`timescale 1ns/1ps
module flash_suspend_resume_protect
  import flash_sr_pkg::*;
#(
  parameter int RESUME_CYCLES = RESUME_CYCLES_DEF
)(
  input wire logic ref_clk, // 25 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire logic cs_active, // Chip select asserted
  input wire logic byte_valid, // Received byte strobe
  input wire logic [7:0] byte_data, // Received byte
  input wire cmd_kind_t ext_kind, // Decoded class, valid at frame end
  input wire logic wp_n_in, // Write-protect pad level, low = protect
  input wire logic wp_n_driven, // Pad is driven from outside
  input wire logic core_busy, // Program or erase engine running
  input wire logic core_erase_active, // Running job is an erase
  input wire logic core_prog_buf2, // Running program uses buffer 2
  input wire logic [2:0] target_sector, // Sector of the framed command
  input wire logic target_sub0b, // Sector 0 part b addressed
  input wire logic [8*SECTORS-1:0] sect_prot_bytes, // Protection bytes
  output logic cmd_go, // Command accepted (pulse)
  output cmd_kind_t cmd_go_kind, // Class of accepted command
  output logic cmd_refused, // Command refused (pulse)
  output logic suspend_req, // Suspend the running job (pulse)
  output logic resume_prog, // Restart program job (pulse)
  output logic resume_erase, // Restart erase job (pulse)
  output logic prog_suspend_buf1, // Program suspended, buffer 1
  output logic prog_suspend_buf2, // Program suspended, buffer 2
  output logic erase_suspend_flag, // Erase suspended
  output logic ready_status, // High when ready
  output logic protect_status // Sector protection in force
);

  initial begin
    if (RESUME_CYCLES < 1) begin
      $error("RESUME_CYCLES must be at least one");
    end
  end

  logic frame_end;
  logic [7:0] byte1_q;
  logic prefix_q;
  logic [7:0] byte4_q;
  logic [2:0] nbytes_q;

  frame_collect u_collect (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .cs_active(cs_active),
    .byte_valid(byte_valid),
    .byte_data(byte_data),
    .frame_end(frame_end),
    .byte1_q(byte1_q),
    .prefix_q(prefix_q),
    .byte4_q(byte4_q),
    .nbytes_q(nbytes_q)
  );

  logic buf1_susp_q, buf2_susp_q, erase_susp_q, sw_prot_q;
  logic [31:0] restart_cnt_q;
  logic restart_erase_q;
  resume_state_t state_q;
  logic any_susp, restarting, wp_asserted, is_prot_seq;
  logic is_suspend, is_resume, prot_en_cmd, prot_dis_cmd;
  logic refuse, blocked, is_prog_erase, frame_cmd;
  cmd_kind_t kind;

  // only the first byte selects suspend or resume
  assign is_suspend = frame_end && nbytes_q != 3'h0 && byte1_q == OP_SUSPEND;
  assign is_resume = frame_end && nbytes_q != 3'h0 && byte1_q == OP_RESUME;
  assign is_prot_seq = nbytes_q == 3'(CMD_BYTES) && byte1_q == PROT_BYTE1 &&
                       prefix_q;
  assign any_susp = buf1_susp_q | buf2_susp_q | erase_susp_q;
  assign restarting = state_q == ST_RESTART;
  // an undriven pad reads as the pull-up level
  assign wp_asserted = wp_n_driven & ~wp_n_in;

  always_comb begin
    kind = ext_kind;
    if (is_prot_seq && byte4_q == PROT_EN_BYTE4) begin
      kind = K_PROT_ENABLE;
    end else if (is_prot_seq && byte4_q == PROT_DIS_BYTE4) begin
      kind = K_PROT_DISABLE;
    end
  end

  assign frame_cmd = frame_end && !is_suspend && !is_resume &&
                     kind != K_NONE;

  // Suspend gating per class
  always_comb begin
    refuse = 1'b0;
    case (kind)
      K_SECTOR_ERASE, K_CHIP_ERASE, K_PROT_ENABLE, K_PROT_DISABLE,
      K_PROT_REG_ERASE, K_PROT_REG_PROG, K_LOCKDOWN, K_LOCK_FREEZE,
      K_SEC_PROG, K_PROG_ERASE, K_PAGE_BLOCK_ERASE: refuse = any_susp;
      K_DPD_ENTER, K_DPD_EXIT, K_UDPD_ENTER: refuse = any_susp;
      K_XFER_BUF1, K_BUF1_WRITE: refuse = buf1_susp_q;
      K_XFER_BUF2, K_BUF2_WRITE: refuse = buf2_susp_q;
      K_PROG_NOERASE: refuse = buf1_susp_q | buf2_susp_q;
      // reads, compares, status and reset pass
      default: refuse = 1'b0;
    endcase
  end

  always_comb begin
    is_prog_erase = 1'b0;
    case (kind)
      K_PROG_ERASE, K_PROG_NOERASE, K_PAGE_BLOCK_ERASE,
      K_SECTOR_ERASE: is_prog_erase = 1'b1;
      default: is_prog_erase = 1'b0;
    endcase
  end

  logic [7:0] sect_byte;
  logic sect_marked;
  assign sect_byte = sect_prot_bytes[8*target_sector +: 8];
  always_comb begin
    if (target_sector == 3'h0) begin
      sect_marked = target_sub0b ?
        sect_byte[SUB0B_LSB +: 2] == SUB_PROT_ON :
        sect_byte[SUB0A_LSB +: 2] == SUB_PROT_ON;
    end else begin
      sect_marked = sect_byte == SECT_PROT_ON;
    end
  end
  assign blocked = protect_status & is_prog_erase & sect_marked;

  // a refused frame only raises the refused pulse
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_go <= 1'b0;
      cmd_refused <= 1'b0;
      cmd_go_kind <= K_NONE;
    end else begin
      cmd_go <= frame_cmd & ~refuse & ~blocked;
      cmd_refused <= frame_cmd & (refuse | blocked);
      if (frame_cmd && !refuse && !blocked) begin
        cmd_go_kind <= kind;
      end
    end
  end

  assign prot_en_cmd = frame_cmd && kind == K_PROT_ENABLE && !refuse;
  assign prot_dis_cmd = frame_cmd && kind == K_PROT_DISABLE && !refuse &&
                        !wp_asserted;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sw_prot_q <= 1'b0;
    end else if (prot_en_cmd) begin
      sw_prot_q <= 1'b1;
    end else if (prot_dis_cmd) begin
      sw_prot_q <= 1'b0;
    end
  end
  assign protect_status = sw_prot_q | wp_asserted;

  // Suspend flags; a soft reset abandons suspended work
  logic take_susp, take_resume, resume_to_prog;
  assign take_susp = is_suspend && core_busy && !restarting;
  assign take_resume = is_resume && !restarting && any_susp;
  assign resume_to_prog = buf1_susp_q | buf2_susp_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      buf1_susp_q <= 1'b0;
      buf2_susp_q <= 1'b0;
      erase_susp_q <= 1'b0;
    end else if (frame_cmd && kind == K_SOFT_RESET) begin
      buf1_susp_q <= 1'b0;
      buf2_susp_q <= 1'b0;
      erase_susp_q <= 1'b0;
    end else if (take_susp) begin
      erase_susp_q <= erase_susp_q | core_erase_active;
      buf1_susp_q <= buf1_susp_q | (~core_erase_active & ~core_prog_buf2);
      buf2_susp_q <= buf2_susp_q | (~core_erase_active & core_prog_buf2);
    end else if (take_resume) begin
      if (resume_to_prog) begin
        buf1_susp_q <= 1'b0;
        buf2_susp_q <= 1'b0;
      end else begin
        erase_susp_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      suspend_req <= 1'b0;
    end else begin
      suspend_req <= take_susp;
    end
  end

  // Pulse leaves its flop one edge after the count reaches zero
  localparam int RESUME_WIN = RESUME_CYCLES + 1;

  // restart delay bounded by resume latency
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      restart_cnt_q <= 32'h0;
      restart_erase_q <= 1'b0;
      resume_prog <= 1'b0;
      resume_erase <= 1'b0;
    end else begin
      resume_prog <= 1'b0;
      resume_erase <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take_resume) begin
            state_q <= ST_RESTART;
            restart_cnt_q <= 32'(RESUME_CYCLES - 1);
            restart_erase_q <= ~resume_to_prog;
          end
        end
        ST_RESTART: begin
          if (restart_cnt_q == 32'h0) begin
            state_q <= ST_IDLE;
            resume_prog <= ~restart_erase_q;
            resume_erase <= restart_erase_q;
          end else begin
            restart_cnt_q <= restart_cnt_q - 32'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign ready_status = ~(core_busy | restarting);

  assign prog_suspend_buf1 = buf1_susp_q;
  assign prog_suspend_buf2 = buf2_susp_q;
  assign erase_suspend_flag = erase_susp_q;

  a_refuse_erase: assert property (@(posedge ref_clk)
    disable iff (!rstn) frame_cmd && any_susp &&
    (kind == K_SECTOR_ERASE || kind == K_CHIP_ERASE || kind == K_LOCKDOWN)
    |=> cmd_refused && !cmd_go)
    else $error("erase class accepted during suspend");

  a_read_pass: assert property (@(posedge ref_clk)
    disable iff (!rstn) frame_cmd && (kind == K_READ_PROT ||
    kind == K_READ_SEC || kind == K_READ_LOCK) |=> cmd_go)
    else $error("protection read refused");

  a_xfer_buf: assert property (@(posedge ref_clk)
    disable iff (!rstn) frame_cmd && kind == K_XFER_BUF1 |=>
    cmd_refused == $past(buf1_susp_q))
    else $error("buffer 1 transfer gating wrong");

  a_compare_pass: assert property (@(posedge ref_clk)
    disable iff (!rstn) frame_cmd && (kind == K_CMP_BUF1 ||
    kind == K_CMP_BUF2) |=> cmd_go && cmd_go_kind == $past(kind))
    else $error("compare refused");

  a_dpd_refuse: assert property (@(posedge ref_clk)
    disable iff (!rstn) frame_cmd && any_susp && (kind == K_DPD_ENTER ||
    kind == K_DPD_EXIT || kind == K_UDPD_ENTER) |=> cmd_refused)
    else $error("power-down accepted during suspend");

  a_status_pass: assert property (@(posedge ref_clk)
    disable iff (!rstn) frame_cmd && (kind == K_READ_STATUS ||
    kind == K_READ_ID || kind == K_READ_CFG || kind == K_SOFT_RESET)
    |=> cmd_go)
    else $error("status or id command refused");

  a_resume_time: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    take_resume |-> ##[1:RESUME_WIN] (resume_prog || resume_erase))
    else $error("resume latency exceeded");

  a_resume_flags: assert property (@(posedge ref_clk)
    disable iff (!rstn) take_resume |=> !ready_status && !buf1_susp_q &&
    !buf2_susp_q &&
    erase_susp_q == ($past(erase_susp_q) && $past(resume_to_prog)))
    else $error("resume left flag set or ready shown");

  a_prog_first: assert property (@(posedge ref_clk)
    disable iff (!rstn) take_resume && erase_susp_q &&
    (buf1_susp_q || buf2_susp_q) |=> erase_susp_q)
    else $error("erase resumed before program");

  a_no_suspend: assert property (@(posedge ref_clk)
    disable iff (!rstn) restarting && is_suspend |=> !suspend_req)
    else $error("suspend taken while restarting");

  a_prot_on: assert property (@(posedge ref_clk)
    disable iff (!rstn) prot_en_cmd |=> protect_status)
    else $error("protection enable missed");

  a_block_marked: assert property (@(posedge ref_clk)
    disable iff (!rstn) frame_cmd && !refuse && is_prog_erase &&
    !(protect_status && sect_marked) |=> cmd_go)
    else $error("unmarked sector blocked");

endmodule : flash_suspend_resume_protect

// ==== test/host_spi_model.sv ====
`timescale 1ns/1ps
module host_spi_model
  import flash_sr_pkg::*;
(
  input wire logic ref_clk, // Bench clock
  output logic cs_active, // Chip select asserted
  output logic byte_valid, // Byte strobe
  output logic [7:0] byte_data, // Shifted byte
  output cmd_kind_t ext_kind // Class at frame end
);
  initial begin
    cs_active = 1'b0;
    byte_valid = 1'b0;
    byte_data = 8'h5A;
    ext_kind = K_NONE;
  end

  // opcode first, then bytes
  // Idle data line toggles so a stale byte is never seen as fresh
  task automatic send_frame(input logic [31:0] seq, input int n,
                            input cmd_kind_t k);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #1;
      cs_active = 1'b1;
      byte_valid = 1'b1;
      byte_data = seq[31-8*i -: 8];
      @(posedge ref_clk);
      #1;
      byte_valid = 1'b0;
      byte_data = ~byte_data;
    end
    @(posedge ref_clk);
    #1;
    cs_active = 1'b0;
    ext_kind = k;
    byte_data = ~byte_data;
    @(posedge ref_clk);
    #1;
    ext_kind = K_NONE;
    byte_data = ~byte_data;
  endtask : send_frame
endmodule : host_spi_model

// ==== test/flash_suspend_resume_protect_tb_top.sv ====
`timescale 1ns/1ps
module flash_suspend_resume_protect_tb_top;
  import flash_sr_pkg::*;
  localparam int RES = 12;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic cs_active, byte_valid, wp_n_in, wp_n_driven, target_sub0b;
  logic [7:0] byte_data;
  cmd_kind_t ext_kind, cmd_go_kind;
  logic core_busy, core_erase_active, core_prog_buf2;
  logic [2:0] target_sector;
  logic [63:0] sect_prot_bytes;
  logic cmd_go, cmd_refused, suspend_req, resume_prog, resume_erase;
  logic prog_suspend_buf1, prog_suspend_buf2, erase_suspend_flag;
  logic ready_status, protect_status;
  int err_count = 0;
  int comparisons = 0;
  int n_go, n_ref, n_susp, n_rp, n_re;
  cmd_kind_t kinds [29] = '{K_SECTOR_ERASE, K_CHIP_ERASE, K_PROT_ENABLE,
    K_PROT_DISABLE, K_PROT_REG_ERASE, K_PROT_REG_PROG, K_LOCKDOWN,
    K_LOCK_FREEZE, K_SEC_PROG, K_DPD_ENTER, K_DPD_EXIT, K_UDPD_ENTER,
    K_XFER_BUF1, K_XFER_BUF2, K_READ_PROT, K_READ_LOCK, K_READ_SEC,
    K_CMP_BUF1, K_CMP_BUF2, K_READ_CFG, K_READ_STATUS, K_READ_ID,
    K_BUF1_WRITE, K_BUF2_WRITE, K_PROG_NOERASE, K_PROG_ERASE,
    K_PAGE_BLOCK_ERASE, K_READ_ARRAY, K_READ_BUF};

  always #20 ref_clk = ~ref_clk;

  host_spi_model u_host_spi_model (.ref_clk(ref_clk),
    .cs_active(cs_active), .byte_valid(byte_valid),
    .byte_data(byte_data), .ext_kind(ext_kind));

  flash_suspend_resume_protect #(.RESUME_CYCLES(RES))
    u_flash_suspend_resume_protect (.ref_clk(ref_clk), .rstn(rstn),
    .cs_active(cs_active), .byte_valid(byte_valid),
    .byte_data(byte_data), .ext_kind(ext_kind), .wp_n_in(wp_n_in),
    .wp_n_driven(wp_n_driven), .core_busy(core_busy),
    .core_erase_active(core_erase_active),
    .core_prog_buf2(core_prog_buf2), .target_sector(target_sector),
    .target_sub0b(target_sub0b), .sect_prot_bytes(sect_prot_bytes),
    .cmd_go(cmd_go), .cmd_go_kind(cmd_go_kind),
    .cmd_refused(cmd_refused), .suspend_req(suspend_req),
    .resume_prog(resume_prog), .resume_erase(resume_erase),
    .prog_suspend_buf1(prog_suspend_buf1),
    .prog_suspend_buf2(prog_suspend_buf2),
    .erase_suspend_flag(erase_suspend_flag),
    .ready_status(ready_status), .protect_status(protect_status));

  // Engine stand-in: stops on suspend, runs again on restart
  always @(posedge ref_clk) begin
    if (suspend_req === 1'b1) core_busy <= 1'b0;
    if (resume_prog === 1'b1 || resume_erase === 1'b1) core_busy <= 1'b1;
    if (cmd_go === 1'b1) n_go++;
    if (cmd_refused === 1'b1) n_ref++;
    if (suspend_req === 1'b1) n_susp++;
    if (resume_prog === 1'b1) n_rp++;
    if (resume_erase === 1'b1) n_re++;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : check

  task automatic issue(input logic [31:0] seq, input int n,
                       input cmd_kind_t k);
    n_go = 0;
    n_ref = 0;
    n_susp = 0;
    u_host_spi_model.send_frame(seq, n, k);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : issue

  task automatic expect_cmd(input cmd_kind_t k, input logic acc);
    issue(32'h11000000, 1, k);
    check(n_go == int'(acc) && n_ref == int'(!acc), "accept or refuse");
    if (acc) check(cmd_go_kind === k, "accepted class");
  endtask : expect_cmd

  task automatic flags_are(input logic [2:0] f, input string m);
    check({erase_suspend_flag, prog_suspend_buf2, prog_suspend_buf1}
          === f, m);
  endtask : flags_are

  function automatic logic acc_bit(input int i, input int s);
    logic [2:0] m;
    m = (i < 12 || i == 25 || i == 26) ? 3'b000 :
        (i == 12 || i == 22) ? 3'b110 :
        (i == 13 || i == 23) ? 3'b101 :
        (i == 24) ? 3'b100 : 3'b111;
    return m[s];
  endfunction : acc_bit

  task automatic wait_resume();
    int i;
    i = 0;
    while (n_rp + n_re == 0 && i < RES + 8) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    if (n_rp + n_re == 0) begin
      err_count++;
      $display("CHECK FAILED at %0t: no restart pulse", $time);
      complete_run();
    end
  endtask : wait_resume

  task automatic suspend_job(input logic er, input logic b2);
    core_erase_active = er;
    core_prog_buf2 = b2;
    core_busy = 1'b1;
    issue(32'hB0000000, 1, K_NONE);
  endtask : suspend_job

  initial begin
    wp_n_in = 1'b1;
    wp_n_driven = 1'b0;
    target_sub0b = 1'b0;
    core_busy = 1'b0;
    core_erase_active = 1'b0;
    core_prog_buf2 = 1'b0;
    target_sector = 3'h2;
    sect_prot_bytes = 64'h00000000_FF000030;
    repeat (4) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    flags_are(3'b000, "flags after reset");
    check(protect_status === 1'b0, "protection after reset");
    wp_n_in = 1'b0;
    @(posedge ref_clk);
    #1;
    check(protect_status === 1'b0, "floating pin protects");
    wp_n_driven = 1'b1;
    @(posedge ref_clk);
    #1;
    check(protect_status === 1'b1, "pin protection status");
    wp_n_in = 1'b1;
    issue(32'h3D2A7FA9, 4, K_NONE);
    check(protect_status === 1'b1, "enable sequence");
    target_sector = 3'h3;
    expect_cmd(K_SECTOR_ERASE, 1'b0);
    target_sector = 3'h2;
    expect_cmd(K_SECTOR_ERASE, 1'b1);
    target_sector = 3'h0;
    target_sub0b = 1'b1;
    expect_cmd(K_PROG_ERASE, 1'b0);
    target_sub0b = 1'b0;
    expect_cmd(K_PROG_ERASE, 1'b1);
    target_sector = 3'h2;
    wp_n_in = 1'b0;
    issue(32'h3D2A7F9A, 4, K_NONE);
    wp_n_in = 1'b1;
    @(posedge ref_clk);
    #1;
    check(protect_status === 1'b1, "disable under pin");
    issue(32'h3D2A7F9A, 4, K_NONE);
    check(protect_status === 1'b0, "disable sequence");
    for (int s = 0; s < 3; s++) begin
      suspend_job(s == 2, s == 1);
      check(n_susp == 1 && n_go == 0 && n_ref == 0, "suspend");
      flags_are(3'b001 << s, "suspend flag");
      check(ready_status === 1'b1, "ready when suspended");
      for (int i = 0; i < 29; i++) begin
        expect_cmd(kinds[i], acc_bit(i, s));
        flags_are(3'b001 << s, "flags moved");
      end
      expect_cmd(K_SOFT_RESET, 1'b1);
      flags_are(3'b000, "reset kept flags");
      core_busy = 1'b0;
    end
    suspend_job(1'b0, 1'b0);
    n_rp = 0;
    n_re = 0;
    issue(32'hD0556600, 3, K_NONE);
    check(n_go == 0 && n_ref == 0, "trailing bytes acted on");
    flags_are(3'b000, "resume flag");
    check(ready_status === 1'b0, "busy after resume");
    // Engine shown busy so only the restart can hold the suspend off
    core_busy = 1'b1;
    issue(32'hB0000000, 1, K_NONE);
    check(n_susp == 0, "suspend while restarting");
    wait_resume();
    check(n_rp == 1 && n_re == 0, "program restart");
    // Host waited for the restart before suspending again
    issue(32'hB0000000, 1, K_NONE);
    check(n_susp == 1 && prog_suspend_buf1 === 1'b1, "resuspend");
    core_busy = 1'b0;
    expect_cmd(K_SOFT_RESET, 1'b1);
    suspend_job(1'b1, 1'b0);
    suspend_job(1'b0, 1'b1);
    flags_are(3'b110, "erase and program suspended");
    n_rp = 0;
    n_re = 0;
    issue(32'hD0000000, 1, K_NONE);
    wait_resume();
    check(n_rp == 1 && n_re == 0, "program resumes first");
    flags_are(3'b100, "erase left suspended");
    core_busy = 1'b0;
    n_rp = 0;
    // Program done, host resumes the erase
    issue(32'hD0000000, 1, K_NONE);
    wait_resume();
    check(n_re == 1 && n_rp == 0, "erase restart");
    flags_are(3'b000, "erase flag cleared");
    complete_run();
  end
endmodule : flash_suspend_resume_protect_tb_top
